// ---- hdl/otp_prog_pkg.sv ----
// Purpose: Constants shared by the calibration-cell programming controller
// Assumes: 250 MHz system clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
package otp_prog_pkg;
   localparam int unsigned CLK_MHZ          = 250;
   // Register offsets (byte addresses, one word each)
   localparam logic [3:0]  OFS_CTRL         = 4'h0;
   localparam logic [3:0]  OFS_TARGET       = 4'h4;
   localparam logic [3:0]  OFS_ALREADY      = 4'h8;
   localparam logic [3:0]  OFS_STATUS       = 4'hC;
   // Field positions
   localparam int unsigned CTRL_START_BIT   = 0;
   localparam int unsigned STAT_BUSY_BIT    = 0;
   localparam int unsigned STAT_DONE_BIT    = 1;
   localparam int unsigned STAT_CELL_LSB    = 4;
   localparam int unsigned STAT_PEND_LSB    = 8;
   localparam int unsigned CELLS            = 9;
   localparam int unsigned SEAL_POS         = 0;
   // Reset values
   localparam logic [8:0]  TARGET_RST       = 9'h000;
   localparam logic [8:0]  ALREADY_RST      = 9'h000;
   // Command bytes
   localparam logic [7:0]  CMD_EXIT_SAVE    = 8'hE1;
   localparam logic [7:0]  CMD_POWER_DOWN   = 8'hA9;
   localparam logic [7:0]  CMD_ENTER_CAL    = 8'h82;
   localparam logic [7:0]  CMD_DATA_STAY    = 8'h80;
   localparam logic [7:0]  CMD_DATA_LEAVE   = 8'h00;
   // Times
   localparam int unsigned REFRESH_US       = 5000;
   localparam int unsigned PULSE_US         = 120000;
   localparam int unsigned SU_SCLK_US       = 1;
   localparam int unsigned HD_SCLK_US       = 1;
   localparam int unsigned DEV_RESET_US     = 1;
   localparam int unsigned REFRESH_CYCLES   = REFRESH_US * CLK_MHZ;
   localparam int unsigned PULSE_CYCLES     = PULSE_US * CLK_MHZ;
   localparam int unsigned SU_SCLK_CYCLES   = SU_SCLK_US * CLK_MHZ;
   localparam int unsigned HD_SCLK_CYCLES   = HD_SCLK_US * CLK_MHZ;
   localparam int unsigned DEV_RESET_CYCLES = DEV_RESET_US * CLK_MHZ;
   localparam int unsigned SCLK_HALF_CYCLES = 4;
   // Bus responses
   localparam logic [1:0]  RESP_OKAY        = 2'b00;
   localparam logic [1:0]  RESP_SLVERR      = 2'b10;
endpackage : otp_prog_pkg

// ---- hdl/otp_cmd_shifter.sv ----
// Purpose: Serialise one command byte, MSB first, onto the device's serial pins
// Assumes: Device samples data on the rising clock edge, clock idles high
// Notes:   Command/data select is always low; busy covers the last clock edge
module otp_cmd_shifter #(
   parameter int unsigned HALF = otp_prog_pkg::SCLK_HALF_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       byte_valid,
   input  wire logic [7:0] byte_data,
   output logic            byte_ready,
   output logic            busy,
   output logic            ser_clk,
   output logic            ser_data,
   output logic            ser_cs_n,
   output logic            ser_dc
);
   logic [7:0]  sh_reg,   sh_next;
   logic [3:0]  bits_reg, bits_next;
   logic [15:0] div_reg,  div_next;
   logic        clk_reg,  clk_next;
   logic        act_reg,  act_next;

   assign byte_ready = !act_reg;
   assign busy       = act_reg;
   assign ser_clk    = clk_reg;
   assign ser_data   = sh_reg[7];
   assign ser_cs_n   = !act_reg;
   assign ser_dc     = 1'b0;

   always_comb begin
      sh_next   = sh_reg;
      bits_next = bits_reg;
      div_next  = div_reg;
      clk_next  = clk_reg;
      act_next  = act_reg;
      if (!act_reg) begin
         if (byte_valid) begin
            sh_next   = byte_data;
            bits_next = 4'd8;
            div_next  = 16'(HALF - 1);
            clk_next  = 1'b1;
            act_next  = 1'b1;
         end
      end else if (div_reg != 16'd0) begin
         div_next = div_reg - 16'd1;
      end else begin
         div_next = 16'(HALF - 1);
         if (bits_reg == 4'd0) begin
            act_next = 1'b0;
         end else if (clk_reg) begin
            clk_next = 1'b0;
            if (bits_reg != 4'd8) begin
               sh_next = {sh_reg[6:0], 1'b0};
            end
         end else begin
            clk_next  = 1'b1;
            bits_next = bits_reg - 4'd1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sh_reg   <= 8'h00;
         bits_reg <= 4'h0;
         div_reg  <= 16'h0000;
         clk_reg  <= 1'b1;
         act_reg  <= 1'b0;
      end else begin
         sh_reg   <= sh_next;
         bits_reg <= bits_next;
         div_reg  <= div_next;
         clk_reg  <= clk_next;
         act_reg  <= act_next;
      end
   end
endmodule : otp_cmd_shifter

// ---- hdl/otp_prog_ctrl.sv ----
// What this block does
// - Programming happens only in calibration shift mode with voltages applied.
// - Never pulse a cell already holding one.
// - Program one cell per pulse: one-hot pattern in the shift register.
// - Any order allowed, but the seal bit goes last.
// - After reset, send exit-power-save, then wait for the refresh.
// - After the wait, power down with display-on cleared, then enter calibration.
// - Send nine data bytes, supply trim first, continuation one, data in bit 0.
// - Apply programming voltages only after the ninth bit is shifted.
// - Keep power-down, display-all and calibration mode while supply pad driven.
// - Hold each programming pulse between 100 and 200 ms, typically 120.
// - At least 1 us between last shift clock and pulse, and after it.
// - Data byte top bit is continuation flag; lowest bit is the shifted data.
//
// Purpose: Host controller that programs the calibration cells of a display driver
// Assumes: AXI4-Lite register access; device reached by its serial command pins
// Notes:   Long waits are parameters so a simulation can shorten them
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
module otp_prog_ctrl #(
   parameter int unsigned REFRESH_CYCLES  = otp_prog_pkg::REFRESH_CYCLES,
   parameter int unsigned PULSE_CYCLES    = otp_prog_pkg::PULSE_CYCLES,
   parameter logic [7:0]  DISPLAY_ALL_CMD = 8'hA5,
   parameter int unsigned SCLK_HALF       = otp_prog_pkg::SCLK_HALF_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             ser_clk,
   output logic             ser_data,
   output logic             ser_cs_n,
   output logic             ser_dc,
   output logic             dev_reset_n,
   output logic             otp_program_voltage_pad_en,
   output logic             panel_supply_input_pad_en
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_DEVRST, ST_WAKE, ST_REFRESH, ST_PDOWN, ST_DALL, ST_CAL,
      ST_SHIFT, ST_SETUP, ST_PULSE, ST_HOLD, ST_EXIT, ST_DRAIN, ST_FINRST
   } state_t;

   // Register file
   logic        aw_full_reg, aw_full_next;
   logic [3:0]  aw_addr_reg, aw_addr_next;
   logic        w_full_reg,  w_full_next;
   logic [31:0] w_data_reg,  w_data_next;
   logic [3:0]  w_strb_reg,  w_strb_next;
   logic        bvalid_reg,  bvalid_next;
   logic [1:0]  bresp_reg,   bresp_next;
   logic        rvalid_reg,  rvalid_next;
   logic [1:0]  rresp_reg,   rresp_next;
   logic [31:0] rdata_reg,   rdata_next;
   logic [8:0]  target_reg,  target_next;
   logic [8:0]  already_reg, already_next;
   logic        start_pulse;
   logic        do_write;

   // Sequencer
   state_t      state_reg,   state_next;
   logic [31:0] cnt_reg,     cnt_next;
   logic [8:0]  pend_reg,    pend_next;
   logic [3:0]  cell_reg,    cell_next;
   logic [3:0]  bit_reg,     bit_next;
   logic        done_reg,    done_next;
   logic        rst_o_reg,   rst_o_next;
   logic        vprog_reg,   vprog_next;
   logic        vsup_reg,    vsup_next;
   logic        cmd_valid;
   logic [7:0]  cmd_byte;
   logic        cmd_ready;
   logic        sh_busy;
   logic [3:0]  pick;
   logic        pick_any;
   logic        busy;

   assign busy          = (state_reg != ST_IDLE);
   assign s_axi_awready = !aw_full_reg && !bvalid_reg;
   assign s_axi_wready  = !w_full_reg && !bvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;
   assign do_write      = aw_full_reg && w_full_reg && !bvalid_reg;
   assign start_pulse   = do_write && (aw_addr_reg == otp_prog_pkg::OFS_CTRL) && w_strb_reg[0]
                          && w_data_reg[otp_prog_pkg::CTRL_START_BIT] && !busy;

   always_comb begin
      aw_full_next = aw_full_reg;
      aw_addr_next = aw_addr_reg;
      w_full_next  = w_full_reg;
      w_data_next  = w_data_reg;
      w_strb_next  = w_strb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rresp_next   = rresp_reg;
      rdata_next   = rdata_reg;
      target_next  = target_reg;
      already_next = already_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_full_next = 1'b1;
         aw_addr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_full_next = 1'b1;
         w_data_next = s_axi_wdata;
         w_strb_next = s_axi_wstrb;
      end
      if (do_write) begin
         aw_full_next = 1'b0;
         w_full_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = otp_prog_pkg::RESP_OKAY;
         if (aw_addr_reg == otp_prog_pkg::OFS_CTRL) begin
            bresp_next = otp_prog_pkg::RESP_OKAY;
         end else if (aw_addr_reg == otp_prog_pkg::OFS_TARGET) begin
            if (w_strb_reg[0]) target_next[7:0] = w_data_reg[7:0];
            if (w_strb_reg[1]) target_next[8]   = w_data_reg[8];
         end else if (aw_addr_reg == otp_prog_pkg::OFS_ALREADY) begin
            if (w_strb_reg[0]) already_next[7:0] = w_data_reg[7:0];
            if (w_strb_reg[1]) already_next[8]   = w_data_reg[8];
         end else if (aw_addr_reg == otp_prog_pkg::OFS_STATUS) begin
            bresp_next = otp_prog_pkg::RESP_OKAY;
         end else begin
            bresp_next = otp_prog_pkg::RESP_SLVERR;
         end
      end
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next  = otp_prog_pkg::RESP_OKAY;
         rdata_next  = 32'h0000_0000;
         if (s_axi_araddr == otp_prog_pkg::OFS_CTRL) begin
            rdata_next = 32'h0000_0000;
         end else if (s_axi_araddr == otp_prog_pkg::OFS_TARGET) begin
            rdata_next[8:0] = target_reg;
         end else if (s_axi_araddr == otp_prog_pkg::OFS_ALREADY) begin
            rdata_next[8:0] = already_reg;
         end else if (s_axi_araddr == otp_prog_pkg::OFS_STATUS) begin
            rdata_next[otp_prog_pkg::STAT_BUSY_BIT] = busy;
            rdata_next[otp_prog_pkg::STAT_DONE_BIT] = done_reg;
            rdata_next[otp_prog_pkg::STAT_CELL_LSB +: 4] = cell_reg;
            rdata_next[otp_prog_pkg::STAT_PEND_LSB +: 9] = pend_reg;
         end else begin
            rresp_next = otp_prog_pkg::RESP_SLVERR;
         end
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 4'h0;
         w_full_reg  <= 1'b0;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= 2'b00;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= 2'b00;
         rdata_reg   <= 32'h0000_0000;
         target_reg  <= otp_prog_pkg::TARGET_RST;
         already_reg <= otp_prog_pkg::ALREADY_RST;
      end else begin
         aw_full_reg <= aw_full_next;
         aw_addr_reg <= aw_addr_next;
         w_full_reg  <= w_full_next;
         w_data_reg  <= w_data_next;
         w_strb_reg  <= w_strb_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         rresp_reg   <= rresp_next;
         rdata_reg   <= rdata_next;
         target_reg  <= target_next;
         already_reg <= already_next;
      end
   end

   // Highest pending position first; seal sits at position 0 so it comes last
   always_comb begin
      pick     = 4'd0;
      pick_any = 1'b0;
      for (int i = 0; i < otp_prog_pkg::CELLS; i++) begin
         if (pend_reg[i]) begin
            pick     = 4'(i);
            pick_any = 1'b1;
         end
      end
   end

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      pend_next  = pend_reg;
      cell_next  = cell_reg;
      bit_next   = bit_reg;
      done_next  = done_reg;
      rst_o_next = rst_o_reg;
      vprog_next = 1'b0;
      vsup_next  = 1'b0;
      cmd_valid  = 1'b0;
      cmd_byte   = otp_prog_pkg::CMD_DATA_LEAVE;
      case (state_reg)
         ST_IDLE: begin
            if (start_pulse) begin
               pend_next  = target_reg & ~already_reg;
               done_next  = 1'b0;
               rst_o_next = 1'b0;
               cnt_next   = otp_prog_pkg::DEV_RESET_CYCLES - 1;
               state_next = ST_DEVRST;
            end
         end
         ST_DEVRST: begin
            if (cnt_reg == 32'd0) begin
               rst_o_next = 1'b1;
               state_next = ST_WAKE;
            end else begin
               cnt_next = cnt_reg - 32'd1;
            end
         end
         ST_WAKE: begin
            cmd_valid = 1'b1;
            cmd_byte  = otp_prog_pkg::CMD_EXIT_SAVE;
            if (cmd_ready) begin
               cnt_next   = REFRESH_CYCLES - 1;
               state_next = ST_REFRESH;
            end
         end
         ST_REFRESH: begin
            // Counted from hand-off, so the wait also covers the byte's own shifting
            if (cnt_reg == 32'd0 && !sh_busy) begin
               state_next = ST_PDOWN;
            end else if (cnt_reg != 32'd0) begin
               cnt_next = cnt_reg - 32'd1;
            end
         end
         ST_PDOWN: begin
            cmd_valid = 1'b1;
            cmd_byte  = otp_prog_pkg::CMD_POWER_DOWN;
            if (cmd_ready) state_next = ST_DALL;
         end
         ST_DALL: begin
            cmd_valid = 1'b1;
            cmd_byte  = DISPLAY_ALL_CMD;
            if (cmd_ready) state_next = ST_CAL;
         end
         ST_CAL: begin
            cmd_valid = 1'b1;
            cmd_byte  = otp_prog_pkg::CMD_ENTER_CAL;
            if (cmd_ready) begin
               if (pick_any) begin
                  cell_next  = pick;
                  bit_next   = 4'(otp_prog_pkg::CELLS - 1);
                  state_next = ST_SHIFT;
               end else begin
                  state_next = ST_EXIT;
               end
            end
         end
         ST_SHIFT: begin
            // One-hot pattern, MSB first, continuation flag set
            cmd_valid = 1'b1;
            cmd_byte  = otp_prog_pkg::CMD_DATA_STAY | {7'h00, bit_reg == cell_reg};
            if (cmd_ready) begin
               if (bit_reg == 4'd0) begin
                  cnt_next   = otp_prog_pkg::SU_SCLK_CYCLES - 1;
                  state_next = ST_SETUP;
               end else begin
                  bit_next = bit_reg - 4'd1;
               end
            end
         end
         ST_SETUP: begin
            if (sh_busy) begin
               cnt_next = otp_prog_pkg::SU_SCLK_CYCLES - 1;
            end else if (cnt_reg == 32'd0) begin
               vprog_next = 1'b1;
               vsup_next  = 1'b1;
               cnt_next   = PULSE_CYCLES - 1;
               state_next = ST_PULSE;
            end else begin
               cnt_next = cnt_reg - 32'd1;
            end
         end
         ST_PULSE: begin
            if (cnt_reg == 32'd0) begin
               pend_next[cell_reg] = 1'b0;
               cnt_next   = otp_prog_pkg::HD_SCLK_CYCLES - 1;
               state_next = ST_HOLD;
            end else begin
               vprog_next = 1'b1;
               vsup_next  = 1'b1;
               cnt_next   = cnt_reg - 32'd1;
            end
         end
         ST_HOLD: begin
            if (cnt_reg == 32'd0) begin
               if (pick_any) begin
                  cell_next  = pick;
                  bit_next   = 4'(otp_prog_pkg::CELLS - 1);
                  state_next = ST_SHIFT;
               end else begin
                  state_next = ST_EXIT;
               end
            end else begin
               cnt_next = cnt_reg - 32'd1;
            end
         end
         ST_EXIT: begin
            cmd_valid = 1'b1;
            cmd_byte  = otp_prog_pkg::CMD_DATA_LEAVE;
            if (cmd_ready) state_next = ST_DRAIN;
         end
         ST_DRAIN: begin
            if (!sh_busy) begin
               rst_o_next = 1'b0;
               cnt_next   = otp_prog_pkg::DEV_RESET_CYCLES - 1;
               state_next = ST_FINRST;
            end
         end
         ST_FINRST: begin
            if (cnt_reg == 32'd0) begin
               rst_o_next = 1'b1;
               done_next  = 1'b1;
               state_next = ST_IDLE;
            end else begin
               cnt_next = cnt_reg - 32'd1;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 32'h0000_0000;
         pend_reg  <= 9'h000;
         cell_reg  <= 4'h0;
         bit_reg   <= 4'h0;
         done_reg  <= 1'b0;
         rst_o_reg <= 1'b1;
         vprog_reg <= 1'b0;
         vsup_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         pend_reg  <= pend_next;
         cell_reg  <= cell_next;
         bit_reg   <= bit_next;
         done_reg  <= done_next;
         rst_o_reg <= rst_o_next;
         vprog_reg <= vprog_next;
         vsup_reg  <= vsup_next;
      end
   end

   // Pads driven only from flip-flops so they never glitch
   assign dev_reset_n                = rst_o_reg;
   assign otp_program_voltage_pad_en = vprog_reg;
   assign panel_supply_input_pad_en  = vsup_reg;

   otp_cmd_shifter #(
      .HALF       (SCLK_HALF)
   ) u_shifter (
      .clk        (clk),
      .arst_n     (arst_n),
      .byte_valid (cmd_valid),
      .byte_data  (cmd_byte),
      .byte_ready (cmd_ready),
      .busy       (sh_busy),
      .ser_clk    (ser_clk),
      .ser_data   (ser_data),
      .ser_cs_n   (ser_cs_n),
      .ser_dc     (ser_dc)
   );
endmodule : otp_prog_ctrl

// ---- dv/otp_prog_checker.sv ----
// Purpose: Port-level checks of the controller
// Assumes: One clock, asynchronous active-low reset
// Notes:   Idle and off counters saturate so long idle spans stay cheap
module otp_prog_checker #(
   parameter int unsigned PULSE_CYCLES = 100
) (
   input wire logic       clk,
   input wire logic       arst_n,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic       ser_clk,
   input wire logic       ser_cs_n,
   input wire logic       ser_dc,
   input wire logic       dev_reset_n,
   input wire logic       otp_program_voltage_pad_en,
   input wire logic       panel_supply_input_pad_en
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   int unsigned hi_reg, hi_next, idle_reg, idle_next, off_reg, off_next;
   always_comb begin
      hi_next = otp_program_voltage_pad_en ? hi_reg + 1 : 0;
      idle_next = ser_clk ? idle_reg + (idle_reg < 1000) : 0;
      off_next = otp_program_voltage_pad_en ? 0 : off_reg + (off_reg < 1000);
   end
   // Saturated at reset: no clock or pulse yet
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hi_reg <= 0;
         idle_reg <= 1000;
         off_reg <= 1000;
      end else begin
         hi_reg <= hi_next;
         idle_reg <= idle_next;
         off_reg <= off_next;
      end
   end
   property p_pads_equal; otp_program_voltage_pad_en == panel_supply_input_pad_en; endproperty
   a_pads_equal: assert property (p_pads_equal) else $error("pad enables differ");
   property p_width; $fell(otp_program_voltage_pad_en) |-> hi_reg == PULSE_CYCLES; endproperty
   a_width: assert property (p_width) else $error("pulse width wrong");
   property p_quiet; otp_program_voltage_pad_en |-> ser_cs_n && ser_clk; endproperty
   a_quiet: assert property (p_quiet) else $error("serial activity during pulse");
   property p_setup; $rose(otp_program_voltage_pad_en) |-> idle_reg >= 250; endproperty
   a_setup: assert property (p_setup) else $error("pulse too soon after clock");
   property p_hold; $fell(ser_clk) |-> off_reg >= 250; endproperty
   a_hold: assert property (p_hold) else $error("clock too soon after pulse");
   property p_dc; ser_dc == 1'b0; endproperty
   a_dc: assert property (p_dc) else $error("data select not low");
   property p_reset_quiet; !dev_reset_n |-> ser_cs_n && !otp_program_voltage_pad_en; endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("activity in device reset");
   property p_live; otp_program_voltage_pad_en |-> dev_reset_n; endproperty
   a_live: assert property (p_live) else $error("pulse while device reset");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_read; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_read: assert property (p_read) else $error("read answer late");
endmodule : otp_prog_checker

// ---- dv/otp_dev_model.sv ----
// Purpose: Behavioural display driver model
// Assumes: Bytes MSB first, sampled on rising serial clock
// Notes:   Refresh taken as instant; cells survive device reset
module otp_dev_model (
   input  wire logic       ser_clk,
   input  wire logic       ser_data,
   input  wire logic       ser_cs_n,
   input  wire logic       dev_reset_n,
   input  wire logic       vprog,
   input  wire logic       vsupply,
   output logic      [8:0] cells
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] sr = 9'h000;
   logic [7:0] sh = 8'h00;
   logic       cal = 1'b0;
   logic       fresh = 1'b0;
   int         n = 0;
   initial cells = 9'h000;
   always @(negedge dev_reset_n) begin
      cal = 1'b0;
      fresh = 1'b0;
      sr = 9'h000;
   end
   always @(negedge ser_cs_n) n = 0;
   always @(posedge ser_clk) begin
      if (!ser_cs_n && dev_reset_n) begin
         sh = {sh[6:0], ser_data};
         n++;
         if (n == 8) begin
            if (cal) begin
               sr = {sr[7:0], sh[0]};
               cal = sh[7];
            end else if (sh == otp_prog_pkg::CMD_EXIT_SAVE) begin
               fresh = 1'b1;
            end else if (sh == otp_prog_pkg::CMD_ENTER_CAL) begin
               cal = fresh && !cells[otp_prog_pkg::SEAL_POS];
            end
         end
      end
   end
   // Delay lets observers see cells before the burn
   always @(posedge vprog or posedge vsupply) begin
      #1;
      if (vprog && vsupply && cal) cells = cells | sr;
   end
endmodule : otp_dev_model

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the programming controller
// Assumes: Short refresh and pulse counts
// Notes:   Watchdog bounds every wait
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, arst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        ser_clk, ser_data, ser_cs_n, ser_dc, dev_reset_n;
   logic        otp_program_voltage_pad_en, panel_supply_input_pad_en;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [8:0]  last_sr = 9'h000;
   int          n_errors = 0, checked = 0, pulses = 0;
   always #2 clk = ~clk;
   otp_prog_ctrl #(.REFRESH_CYCLES(200), .PULSE_CYCLES(100)) otp_prog_ctrl_i (.*);
   otp_dev_model otp_dev_model_i (.ser_clk, .ser_data, .ser_cs_n, .dev_reset_n,
      .vprog(otp_program_voltage_pad_en), .vsupply(panel_supply_input_pad_en), .cells());
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      if (n_errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   // Sampled before the model burns, so old cell state is visible
   always @(posedge otp_program_voltage_pad_en) begin
      pulses++;
      if (otp_dev_model_i.cal) begin
         chk(32'($countones(otp_dev_model_i.sr)), 32'h0000_0001);
         chk(32'(otp_dev_model_i.sr & otp_dev_model_i.cells), 32'h0000_0000);
         last_sr = otp_dev_model_i.sr;
      end
   end
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      fork
         begin
            do @(posedge clk); while (!s_axi_awready);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge clk); while (!s_axi_wready);
            s_axi_wvalid <= 1'b0;
         end
      join
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b1;
      @(posedge clk);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(otp_prog_pkg::RESP_OKAY));
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : rd
   // Second start, sent while busy, is ignored
   task automatic run_prog(input logic [8:0] tgt, input logic [8:0] done_bits, input int n_exp,
                           input logic [8:0] cells_exp);
      logic [31:0] d;
      logic [1:0]  r;
      wr(otp_prog_pkg::OFS_TARGET, {23'h0, tgt});
      wr(otp_prog_pkg::OFS_ALREADY, {23'h0, done_bits});
      pulses = 0;
      wr(otp_prog_pkg::OFS_CTRL, 32'h0000_0001);
      wr(otp_prog_pkg::OFS_CTRL, 32'h0000_0001);
      do rd(otp_prog_pkg::OFS_STATUS, d, r); while (d[1] !== 1'b1);
      chk(32'(pulses), 32'(n_exp));
      chk(32'(otp_dev_model_i.cells), 32'(cells_exp));
   endtask : run_prog
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0]  r;
      rd(otp_prog_pkg::OFS_TARGET, d, r);
      chk(d, 32'h0000_0000);
      rd(otp_prog_pkg::OFS_STATUS, d, r);
      chk(d, 32'h0000_0000);
      rd(4'h2, d, r);
      chk(32'(r), 32'(otp_prog_pkg::RESP_SLVERR));
   endtask : t_regs
   task automatic t_fresh();
      run_prog(9'h120, 9'h000, 2, 9'h120);
   endtask : t_fresh
   task automatic t_seal_last();
      run_prog(9'h123, 9'h120, 2, 9'h123);
      chk(32'(last_sr), 32'h0000_0001);
   endtask : t_seal_last
   task automatic t_sealed();
      run_prog(9'h004, 9'h123, 1, 9'h123);
   endtask : t_sealed
   task automatic t_nothing();
      run_prog(9'h123, 9'h123, 0, 9'h123);
   endtask : t_nothing
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      t_regs();
      t_fresh();
      t_seal_last();
      t_sealed();
      t_nothing();
      report_and_stop();
   end
   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end
endmodule : tb_top
bind otp_prog_ctrl otp_prog_checker #(.PULSE_CYCLES(PULSE_CYCLES)) otp_prog_checker_i (.*);
